// ==== logic/spbcl_strap_latch.sv ====
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module spbcl_strap_latch #(
  parameter int ADDR_W = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_module_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output var logic [31:0] o_rdata,
  input wire spbcl_pkg::spbcl_straps_t i_strap_pins,
  output var logic [4:0] o_pull_en,
  output var logic [4:0] o_pull_up,
  output var logic o_pins_normal,
  output var logic o_strap_valid,
  output var spbcl_pkg::spbcl_cfg_t o_cfg,
  output var logic o_uart0_transmit_log_en
);
  import spbcl_pkg::*;

  typedef enum logic [1:0] {
    SPBCL_ST_OFF,
    SPBCL_ST_RESET,
    SPBCL_ST_CAPTURE,
    SPBCL_ST_RUN
  } spbcl_state_t;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic spbcl_edge_t spbcl_edge_dec(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: spbcl_edge_dec = SPBCL_EDGE_FS_FO;
      2'b01: spbcl_edge_dec = SPBCL_EDGE_FS_RO;
      2'b10: spbcl_edge_dec = SPBCL_EDGE_RS_FO;
      default: spbcl_edge_dec = SPBCL_EDGE_RS_RO;
    endcase
  endfunction : spbcl_edge_dec

  function automatic spbcl_boot_t spbcl_boot_dec(input logic a, input logic b);
    if (a) begin
      spbcl_boot_dec = SPBCL_BOOT_SPI_FLASH;
    end else if (!b) begin
      spbcl_boot_dec = SPBCL_BOOT_DOWNLOAD;
    end else begin
      spbcl_boot_dec = SPBCL_BOOT_UNDEFINED;
    end
  endfunction : spbcl_boot_dec

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  logic [4:0] pins_sync;

  spbcl_pin_sync #(
    .WIDTH(SPBCL_NUM_STRAPS)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_strap_pins),
    .i_rst_val(SPBCL_PULL_UP_MASK),
    .o_sync(pins_sync)
  );

  // ****************************************************************
  // Capture state machine
  // ****************************************************************
  spbcl_state_t state_reg;
  spbcl_state_t state_next;
  logic [4:0] strap_reg;
  logic [4:0] strap_next;
  logic valid_reg;
  logic valid_next;

  // Goes to OFF on reset, captures once two cycles after its release or after re-enable
  always_comb begin
    state_next = state_reg;
    strap_next = strap_reg;
    valid_next = valid_reg;
    case (state_reg)
      SPBCL_ST_OFF: begin
        if (i_module_en) begin
          state_next = SPBCL_ST_RESET;
        end
      end
      SPBCL_ST_RESET: begin
        state_next = SPBCL_ST_CAPTURE;
      end
      SPBCL_ST_CAPTURE: begin
        // Latch the held levels from the three-stage sampler and flag them valid
        strap_next = pins_sync;
        valid_next = 1'b1;
        state_next = SPBCL_ST_RUN;
      end
      SPBCL_ST_RUN: begin
        strap_next = strap_reg;
      end
      default: begin
        state_next = SPBCL_ST_OFF;
      end
    endcase
    if (!i_module_en) begin
      state_next = SPBCL_ST_OFF;
      valid_next = 1'b0;
    end
  end

  // Synchronous reset returns to the pull-hold phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= SPBCL_ST_OFF;
      strap_reg <= SPBCL_PULL_UP_MASK;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      strap_reg <= strap_next;
      valid_reg <= valid_next;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [4:0] ovr_reg;
  logic [4:0] ovr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  spbcl_cfg_t cfg_now;

  // Override writes and read mux
  always_comb begin
    ovr_next = ovr_reg;
    rdata_next = SPBCL_RD_UNMAPPED;
    if (i_wr && i_addr == SPBCL_ADDR_OVR) begin
      ovr_next = i_wdata[4:0];
    end
    if (i_rd) begin
      case (i_addr)
        SPBCL_ADDR_STRAP: rdata_next = {27'h0, strap_reg};
        SPBCL_ADDR_OVR: rdata_next = {27'h0, ovr_reg};
        SPBCL_ADDR_CFG: rdata_next = {26'h0, cfg_now};
        default: rdata_next = SPBCL_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ovr_reg <= SPBCL_OVR_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ovr_reg <= ovr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  always_comb begin
    cfg_now.boot_source = spbcl_boot_dec(strap_reg[SPBCL_BIT_BOOT_A],
                                         strap_reg[SPBCL_BIT_BOOT_B]);
    cfg_now.vsel_1v8 = strap_reg[SPBCL_BIT_FLASH];
    cfg_now.boot_log_on = strap_reg[SPBCL_BIT_LOG];
    cfg_now.sdio_edge = spbcl_edge_dec(strap_reg[SPBCL_BIT_LOG],
                                       strap_reg[SPBCL_BIT_SDIO]);
    if (ovr_reg[SPBCL_OVR_VSEL_EN]) begin
      cfg_now.vsel_1v8 = ovr_reg[SPBCL_OVR_VSEL_VAL];
    end
    if (ovr_reg[SPBCL_OVR_EDGE_EN]) begin
      cfg_now.sdio_edge = spbcl_edge_dec(ovr_reg[SPBCL_OVR_EDGE_HI],
                                         ovr_reg[SPBCL_OVR_EDGE_LO]);
    end
  end

  spbcl_cfg_t cfg_reg;
  logic pull_reg;
  logic pull_next;

  // Pulls stay attached until the capture is done
  always_comb begin
    pull_next = (state_next != SPBCL_ST_RUN);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_reg <= '0;
      pull_reg <= 1'b1;
    end else begin
      cfg_reg <= cfg_now;
      pull_reg <= pull_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rdata = rdata_reg;
  assign o_pull_en = {5{pull_reg}};
  assign o_pull_up = SPBCL_PULL_UP_MASK;
  assign o_pins_normal = ~pull_reg;
  assign o_strap_valid = valid_reg;
  assign o_cfg = cfg_reg;
  assign o_uart0_transmit_log_en = cfg_reg.boot_log_on & valid_reg;

endmodule : spbcl_strap_latch

`default_nettype wire

// ==== logic/spbcl_pkg.sv ====
package spbcl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] SPBCL_ADDR_STRAP = 4'h0; // Latched strap status, read only
  localparam logic [3:0] SPBCL_ADDR_OVR = 4'h1;   // Firmware override control
  localparam logic [3:0] SPBCL_ADDR_CFG = 4'h2;   // Effective configuration, read only
  localparam logic [31:0] SPBCL_RD_UNMAPPED = 32'h0000_0000;

  // ****************************************************************
  // Strap bit positions in the status word
  // ****************************************************************
  localparam int SPBCL_BIT_FLASH = 0;
  localparam int SPBCL_BIT_LOG = 1;
  localparam int SPBCL_BIT_BOOT_A = 2;
  localparam int SPBCL_BIT_BOOT_B = 3;
  localparam int SPBCL_BIT_SDIO = 4;
  localparam int SPBCL_NUM_STRAPS = 5;

  // ****************************************************************
  // Override register fields
  // ****************************************************************
  localparam int SPBCL_OVR_VSEL_EN = 0;
  localparam int SPBCL_OVR_VSEL_VAL = 1;
  localparam int SPBCL_OVR_EDGE_EN = 2;
  localparam int SPBCL_OVR_EDGE_LO = 3;
  localparam int SPBCL_OVR_EDGE_HI = 4;
  localparam logic [4:0] SPBCL_OVR_RESET = 5'h00;

  // ****************************************************************
  // Pull directions: 1 = pull-up, 0 = pull-down, per strap bit
  // ****************************************************************
  localparam logic [4:0] SPBCL_PULL_UP_MASK = 5'h16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SPBCL_EDGE_FS_FO,
    SPBCL_EDGE_FS_RO,
    SPBCL_EDGE_RS_FO,
    SPBCL_EDGE_RS_RO
  } spbcl_edge_t;

  typedef enum logic [1:0] {
    SPBCL_BOOT_SPI_FLASH,
    SPBCL_BOOT_DOWNLOAD,
    SPBCL_BOOT_UNDEFINED
  } spbcl_boot_t;

  // Packed MSB first, so the flash strap lands on bit 0 of the status word
  typedef struct packed {
    logic sdio_edge_strap;
    logic boot_mode_strap_b;
    logic boot_mode_strap_a;
    logic log_control_strap;
    logic flash_supply_strap;
  } spbcl_straps_t;

  typedef struct packed {
    spbcl_boot_t boot_source;
    logic vsel_1v8;
    logic boot_log_on;
    spbcl_edge_t sdio_edge;
  } spbcl_cfg_t;

endpackage : spbcl_pkg

// ==== logic/spbcl_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module spbcl_pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_rst_val,
  output var logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // ****************************************************************
  // Three-stage sampler; a level counts once stages two and three agree
  // ****************************************************************
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  // Registers only; stage one feeds stage two alone
  always_ff @(posedge i_clk) begin
    s1_reg <= i_async;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (i_sys_rst) begin
      out_reg <= i_rst_val;
    end else begin
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;

endmodule : spbcl_pin_sync

`default_nettype wire

// ==== test/spbcl_strap_latch_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module spbcl_strap_latch_properties #(
  parameter int ADDR_W = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_module_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [4:0] o_pull_en,
  input wire logic o_pins_normal,
  input wire logic o_strap_valid,
  input wire spbcl_pkg::spbcl_cfg_t o_cfg,
  input wire logic o_uart0_transmit_log_en
);
  import spbcl_pkg::*;
  // One clock, one reset for every property
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_reset_pulls: assert property ($fell(i_sys_rst) |-> o_pull_en == 5'h1f)
    else $error("pulls off in reset");
  a_capture_time: assert property ($fell(i_sys_rst) && i_module_en ##1 i_module_en [*2]
    |-> !o_strap_valid ##1 o_strap_valid) else $error("capture edge wrong");
  a_pins_back: assert property (o_strap_valid |-> o_pins_normal && !o_pull_en)
    else $error("pins not released");
  a_strap_hold: assert property ((o_strap_valid && i_module_en && !i_wr) [*3]
    |-> $stable(o_cfg)) else $error("config moved");
  a_read_idle: assert property (!$past(i_rd) |-> !o_rdata)
    else $error("read data outside slot");
  a_log_gate: assert property (o_uart0_transmit_log_en == (o_strap_valid && o_cfg.boot_log_on))
    else $error("log enable wrong");
  a_vsel_ovr: assert property (o_strap_valid && i_wr && i_addr == SPBCL_ADDR_OVR && i_wdata[0]
    ##1 !i_wr |=> o_cfg.vsel_1v8 == $past(i_wdata[1], 2)) else $error("supply override lost");
  a_edge_ovr: assert property (o_strap_valid && i_wr && i_addr == SPBCL_ADDR_OVR && i_wdata[2]
    ##1 !i_wr |=> o_cfg.sdio_edge == $past(i_wdata[4:3], 2)) else $error("edge override lost");
  a_en_idle: assert property (!i_module_en |=> !o_strap_valid)
    else $error("valid while disabled");
endmodule : spbcl_strap_latch_properties

bind spbcl_strap_latch spbcl_strap_latch_properties #(.ADDR_W(ADDR_W)) u_props (.i_clk, .i_sys_rst,
  .i_module_en, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pull_en, .o_pins_normal,
  .o_strap_valid, .o_cfg, .o_uart0_transmit_log_en);
`default_nettype wire

// ==== test/spbcl_strap_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Strap driver model
// ****************
module spbcl_strap_host (
  input wire logic i_clk,
  input wire logic i_hold,
  input wire spbcl_pkg::spbcl_straps_t i_level,
  input wire logic [4:0] i_pull_en,
  input wire logic [4:0] i_pull_up,
  output var spbcl_pkg::spbcl_straps_t o_pins
);
  import spbcl_pkg::*;
  logic [4:0] flip = 5'h0a;
  // Floating pins show the inverse of their last level
  always @(posedge i_clk) flip <= ~o_pins;
  // Host drive first, then weak pulls (bit order matches the strap struct)
  always_comb begin
    if (i_hold)
      o_pins = i_level;
    else if (|i_pull_en)
      o_pins = i_pull_up;
    else
      o_pins = flip;
  end
endmodule : spbcl_strap_host
`default_nettype wire

// ==== test/spbcl_strap_latch_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench top
// ****************
module spbcl_strap_latch_tb;
  import spbcl_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_module_en = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic hold = 1'b0;
  logic [31:0] o_rdata;
  logic [4:0] o_pull_en;
  logic [4:0] o_pull_up;
  spbcl_straps_t level = 5'h00;
  spbcl_straps_t pins;
  spbcl_cfg_t o_cfg;
  logic [31:0] exp_q[$];
  int fails = 0;
  int checks_done = 0;

  spbcl_strap_latch DUT (.i_clk, .i_sys_rst, .i_module_en, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_strap_pins(pins), .o_pull_en, .o_pull_up, .o_pins_normal(), .o_strap_valid(),
    .o_cfg, .o_uart0_transmit_log_en());
  spbcl_strap_host HOST (.i_clk, .i_hold(hold), .i_level(level), .i_pull_en(o_pull_en),
    .i_pull_up(o_pull_up), .o_pins(pins));

  // 100 MHz clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t read %h, expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // One bus cycle; for a read, d is the expected data
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    if (!w)
      exp_q.push_back(d);
  endtask : bus

  task automatic idle();
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask : idle

  // Reset with straps held (or left to the pulls) around the release
  task automatic capture(input spbcl_straps_t lv, input logic h);
    @(posedge i_clk);
    hold <= h;
    level <= lv;
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    hold <= 1'b0;
  endtask : capture

  function automatic logic [31:0] cfg_exp(input spbcl_straps_t s, input logic [4:0] o);
    spbcl_cfg_t c;
    c.boot_source = s.boot_mode_strap_a ? SPBCL_BOOT_SPI_FLASH :
      (s.boot_mode_strap_b ? SPBCL_BOOT_UNDEFINED : SPBCL_BOOT_DOWNLOAD);
    c.vsel_1v8 = o[0] ? o[1] : s.flash_supply_strap;
    c.boot_log_on = s.log_control_strap;
    c.sdio_edge = spbcl_edge_t'(o[2] ? o[4:3] : {s.log_control_strap, s.sdio_edge_strap});
    return {26'h0, c};
  endfunction : cfg_exp

  // Note each read, compare it in the cycle after
  always @(posedge i_clk) rd_seen <= i_rd;
  always @(negedge i_clk) begin
    if (rd_seen)
      chk(o_rdata, exp_q.pop_front());
  end

  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    summarize();
  end

  // Main sequence: pull defaults, then every boot code with both log strap levels
  initial begin
    spbcl_straps_t lv;
    logic [31:0] r;
    logic [31:0] d;
    void'($urandom(32'hadf6b42f));
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int i = -1; i < 8; i++) begin
      r = $urandom;
      d = $urandom;
      lv = r[4:0];
      lv.boot_mode_strap_a = i[0];
      lv.boot_mode_strap_b = i[1];
      lv.log_control_strap = i[2];
      d[0] = i[1];
      d[2] = i[0];
      if (i < 0)
        lv = 5'h16;
      capture(lv, i >= 0);
      bus(1'b1, SPBCL_ADDR_STRAP, r);
      bus(1'b0, SPBCL_ADDR_STRAP, {27'h0, lv});
      bus(1'b0, SPBCL_ADDR_CFG, cfg_exp(lv, 5'h00));
      bus(1'b1, SPBCL_ADDR_OVR, d);
      bus(1'b0, SPBCL_ADDR_OVR, {27'h0, d[4:0]});
      bus(1'b0, SPBCL_ADDR_CFG, cfg_exp(lv, d[4:0]));
      bus(1'b0, 4'h7, SPBCL_RD_UNMAPPED);
      idle();
    end
    @(posedge i_clk);
    i_module_en <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_module_en <= 1'b1;
    repeat (6) @(posedge i_clk);
    bus(1'b0, SPBCL_ADDR_STRAP, 32'h0000_0016);
    idle();
    repeat (3) @(posedge i_clk);
    summarize();
  end
endmodule : spbcl_strap_latch_tb
`default_nettype wire
